// ### rtl/rlim_fifo.sv
// Synchronous FIFO with a registered output stage.
// Assumes DEPTH is a power of two; one clock, async active-low reset.
`timescale 1ns/1ps
module rlim_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic push;
  logic load;

  assign in_ready = (count_reg != FULL_COUNT);
  assign push = in_valid && in_ready;
  assign load = (count_reg != '0) && (!out_valid_reg || out_ready);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  always_ff @(posedge clock) begin
    if (clk_en && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !load) begin
        count_reg <= count_reg + 1'b1;
      end else if (load && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // Output register: refilled from memory when empty or being taken
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else if (clk_en) begin
      if (load) begin
        out_valid_reg <= 1'b1;
        out_data_reg <= mem[rd_ptr_reg];
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

endmodule

// ### rtl/rlim_pkg.sv
// Constants and types shared by the receive line input monitor.
// Assumes a 10 MHz system clock; the line clock arrives from the line interface.
package rlim_pkg;

  // System clock rate and loss-of-clock interval
  localparam int unsigned CLK_FREQ_KHZ = 10000;
  localparam int unsigned LOC_TIME_US = 250;
  // Least time: round up to whole cycles
  localparam int unsigned LOC_CYCLES = (LOC_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int unsigned LOC_CNT_W = 12;
  localparam logic [LOC_CNT_W-1:0] LOC_LIMIT = LOC_CNT_W'(LOC_CYCLES);

  // Sample word layout: {single_rail, pos[7:0], neg[7:0]}
  localparam int unsigned SAMPLES_PER_WORD = 8;
  localparam int unsigned WORD_W = 2 * SAMPLES_PER_WORD + 1;
  localparam int unsigned WORD_SINGLE_BIT = 16;
  localparam int unsigned WORD_POS_LSB = 8;
  localparam int unsigned WORD_NEG_LSB = 0;
  localparam logic [2:0] LAST_SAMPLE = 3'h7;

  // Buffering and counter defaults
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned BPV_W = 16;

  // Line standard chosen by the select pin; high selects CEPT
  typedef enum logic {
    RLIM_DS1 = 1'b0,
    RLIM_CEPT = 1'b1
  } rlim_std_type;
  localparam rlim_std_type STD_RESET = RLIM_DS1;

  // Start-up sequence, Gray coded
  typedef enum logic [1:0] {
    ST_SYNC1 = 2'b00,
    ST_SYNC2 = 2'b01,
    ST_CAPTURE = 2'b11,
    ST_RUN = 2'b10
  } rlim_state_type;

endpackage

// ### rtl/rlim_top.sv
// Receive line input stage: rail sampling, violation counting, loss-of-clock watch.
// Assumes rails change on falling line clock edges; line clock may stop at any time.
`timescale 1ns/1ps
module rlim_top #(
  parameter int BPV_WIDTH = rlim_pkg::BPV_W,
  parameter int DEPTH = rlim_pkg::FIFO_DEPTH
) (
  // System clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Line interface
  input wire logic line_receive_clock,
  input wire logic positive_rail_in,
  input wire logic negative_rail_in,
  // Static configuration pins
  input wire logic single_rail_sel,
  input wire logic line_standard_select,
  // Status
  output logic loss_of_line_clock_flag,
  output rlim_pkg::rlim_std_type line_standard_mode,
  output logic [BPV_WIDTH-1:0] bpv_count,
  output logic overrun_flag,
  // Sample stream toward the framer
  output logic rx_valid,
  output logic [rlim_pkg::SAMPLES_PER_WORD-1:0] rx_pos_bits,
  output logic [rlim_pkg::SAMPLES_PER_WORD-1:0] rx_neg_bits,
  output logic rx_single_rail,
  input wire logic rx_ready
);
  import rlim_pkg::*;

  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Line clock domain
  logic lrst_s1, lrst_n_reg;
  logic ce_l_s1, ce_l_reg;
  logic single_l_s1, single_l_reg;
  logic [7:0] pos_sh_reg, neg_sh_reg;
  logic [2:0] bit_cnt_reg;
  logic [WORD_W-1:0] word_reg;
  logic word_tgl_reg;

  // Reset asserts at once, releases on line clock edges
  always_ff @(posedge line_receive_clock or negedge rst_n) begin
    if (!rst_n) begin
      lrst_s1 <= 1'b0;
      lrst_n_reg <= 1'b0;
    end else begin
      lrst_s1 <= 1'b1;
      lrst_n_reg <= lrst_s1;
    end
  end

  always_ff @(posedge line_receive_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      ce_l_s1 <= 1'b0;
      ce_l_reg <= 1'b0;
      single_l_s1 <= 1'b0;
      single_l_reg <= 1'b0;
    end else begin
      ce_l_s1 <= clk_en;
      ce_l_reg <= ce_l_s1;
      single_l_s1 <= single_rail_sel;
      single_l_reg <= single_l_s1;
    end
  end

  // Rising-edge sampling of both rails, gathered into words of eight
  always_ff @(posedge line_receive_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      pos_sh_reg <= 8'h00;
      neg_sh_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      word_reg <= '0;
      word_tgl_reg <= 1'b0;
    end else if (ce_l_reg) begin
      pos_sh_reg <= {pos_sh_reg[6:0], positive_rail_in};
      neg_sh_reg <= {neg_sh_reg[6:0], negative_rail_in};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == LAST_SAMPLE) begin
        // Single-rail tag tells the system side how to read the negative rail
        word_reg <= {single_l_reg, pos_sh_reg[6:0], positive_rail_in,
                     neg_sh_reg[6:0], negative_rail_in};
        word_tgl_reg <= ~word_tgl_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the system domain
  logic tgl_s1, tgl_s2, tgl_s3;
  logic new_word, fifo_in_ready;

  // word_reg holds for eight line clocks, well past the toggle's sync delay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else if (clk_en) begin
      tgl_s1 <= word_tgl_reg;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end
  assign new_word = clk_en && (tgl_s2 != tgl_s3);

  ////////////////////////////////////////////////////////////////////////////
  // Violation counter and overrun
  logic [BPV_WIDTH-1:0] bpv_count_reg;
  logic [BPV_WIDTH:0] bpv_sum;
  logic overrun_reg;

  assign bpv_sum = {1'b0, bpv_count_reg} + (BPV_WIDTH+1)'(ones8(word_reg[7:0]));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bpv_count_reg <= '0;
    end else if (new_word && word_reg[WORD_SINGLE_BIT]) begin
      // Saturates rather than wrapping
      bpv_count_reg <= bpv_sum[BPV_WIDTH] ? '1 : bpv_sum[BPV_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (new_word && !fifo_in_ready) begin
      overrun_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample buffer
  logic [WORD_W-1:0] fifo_out_data;

  rlim_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(new_word),
    .in_data(word_reg),
    .in_ready(fifo_in_ready),
    .out_valid(rx_valid),
    .out_data(fifo_out_data),
    .out_ready(rx_ready)
  );

  assign rx_single_rail = fifo_out_data[WORD_SINGLE_BIT];
  assign rx_pos_bits = fifo_out_data[WORD_POS_LSB +: SAMPLES_PER_WORD];
  assign rx_neg_bits = fifo_out_data[WORD_NEG_LSB +: SAMPLES_PER_WORD];
  assign bpv_count = bpv_count_reg;
  assign overrun_flag = overrun_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Loss-of-line-clock watch
  logic lck_s1, lck_s2, lck_s3, lck_trans;
  logic [LOC_CNT_W-1:0] loc_cnt_reg;
  logic loss_flag_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lck_s1 <= 1'b0;
      lck_s2 <= 1'b0;
      lck_s3 <= 1'b0;
    end else if (clk_en) begin
      lck_s1 <= line_receive_clock;
      lck_s2 <= lck_s1;
      lck_s3 <= lck_s2;
    end
  end
  assign lck_trans = (lck_s2 != lck_s3);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loc_cnt_reg <= '0;
    end else if (clk_en) begin
      if (lck_trans) begin
        loc_cnt_reg <= '0;
      end else if (loc_cnt_reg != LOC_LIMIT) begin
        loc_cnt_reg <= loc_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loss_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (lck_trans) begin
        loss_flag_reg <= 1'b0;
      end else if (loc_cnt_reg == LOC_LIMIT - 1'b1) begin
        loss_flag_reg <= 1'b1;
      end
    end
  end
  assign loss_of_line_clock_flag = loss_flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Line standard captured after reset release
  logic std_s1, std_s2;
  rlim_state_type st_reg;
  rlim_std_type mode_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      std_s1 <= 1'b0;
      std_s2 <= 1'b0;
    end else if (clk_en) begin
      std_s1 <= line_standard_select;
      std_s2 <= std_s1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_SYNC1;
      mode_reg <= STD_RESET;
    end else if (clk_en) begin
      case (st_reg)
        ST_SYNC1: st_reg <= ST_SYNC2;
        ST_SYNC2: st_reg <= ST_CAPTURE;
        ST_CAPTURE: begin
          mode_reg <= rlim_std_type'(std_s2);
          st_reg <= ST_RUN;
        end
        ST_RUN: st_reg <= ST_RUN;
        default: st_reg <= ST_SYNC1;
      endcase
    end
  end
  assign line_standard_mode = mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_loc_raise: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(loss_flag_reg) |-> $past(loc_cnt_reg) == LOC_LIMIT - 1'b1 && !$past(lck_trans))
    else $error("loss flag rose without a full quiet interval");
  a_loc_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && lck_trans && loss_flag_reg) |=> !loss_flag_reg)
    else $error("loss flag not cleared on line clock edge");
  a_cnt_restart: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && lck_trans) |=> loc_cnt_reg == '0 && !loss_flag_reg)
    else $error("loss timer not restarted by transition");
  a_pos_sample: assert property (@(posedge line_receive_clock)
    disable iff (!lrst_n_reg)
    ce_l_reg |=> pos_sh_reg[0] == $past(positive_rail_in))
    else $error("positive rail not sampled");
  a_neg_sample: assert property (@(posedge line_receive_clock)
    disable iff (!lrst_n_reg)
    (ce_l_reg && !single_l_reg) |=> neg_sh_reg[0] == $past(negative_rail_in))
    else $error("negative rail not sampled in dual rail");
  a_single_word: assert property (@(posedge line_receive_clock)
    disable iff (!lrst_n_reg)
    (ce_l_reg && bit_cnt_reg == LAST_SAMPLE) |=>
      word_reg[WORD_SINGLE_BIT] == $past(single_l_reg) &&
      word_reg[WORD_POS_LSB +: 8] == {$past(pos_sh_reg[6:0]), $past(positive_rail_in)})
    else $error("word does not carry positive rail stream");
  a_bpv_incr: assert property (@(posedge clock) disable iff (!rst_n)
    (new_word && word_reg[WORD_SINGLE_BIT] && !bpv_sum[BPV_WIDTH]) |=>
      bpv_count_reg == $past(bpv_count_reg) + BPV_WIDTH'($past(ones8(word_reg[7:0]))))
    else $error("violation count step wrong");
  a_bpv_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !(new_word && word_reg[WORD_SINGLE_BIT]) |=> $stable(bpv_count_reg))
    else $error("violation count moved without single rail word");
  a_mode_start: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && st_reg == ST_CAPTURE) |=> mode_reg == rlim_std_type'($past(std_s2)) &&
      st_reg == ST_RUN)
    else $error("line standard not taken at start");

  c_loss_raise: cover property (@(posedge clock) disable iff (!rst_n) $rose(loss_flag_reg));
  c_loss_clear: cover property (@(posedge clock) disable iff (!rst_n) $fell(loss_flag_reg));
  c_bpv_step: cover property (@(posedge clock) disable iff (!rst_n)
    new_word && word_reg[WORD_SINGLE_BIT] && word_reg[7:0] != 8'h00);
  c_overrun: cover property (@(posedge clock) disable iff (!rst_n) $rose(overrun_reg));

endmodule

// ### tb/rlim_liu_model.sv
// Behavioural line interface unit: recovered line clock and two NRZ rails.
// Assumes the bench calls one task at a time; the clock stays low between bursts.
`timescale 1ns/1ps
module rlim_liu_model (
  // Line side toward the receiver
  output logic line_receive_clock,
  output logic positive_rail_in,
  output logic negative_rail_in
);
  initial begin
    line_receive_clock = 1'b0;
    positive_rail_in = 1'b0;
    negative_rail_in = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One 80 ns bit cell: rails change while the clock is low
  task automatic send_bit(input logic p, input logic n);
    positive_rail_in = p;
    negative_rail_in = n;
    #40 line_receive_clock = 1'b1;
    #40 line_receive_clock = 1'b0;
  endtask
  // Burst over: rails stop holding the last bit
  task automatic stop();
    #40;
    positive_rail_in = ~positive_rail_in;
    negative_rail_in = ~negative_rail_in;
  endtask
  // A lone clock edge, rising or falling
  task automatic lone_edge();
    #40 line_receive_clock = ~line_receive_clock;
  endtask
endmodule

// ### tb/tb_rlim_top.sv
// Testbench for the receive line input monitor: rails, violations, clock loss.
// Assumes the partner model rlim_liu_model and the design under rtl/.
`timescale 1ns/1ps
`define CHK(a, b, msg) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED at %0t: %s", $time, msg); end end
module tb_rlim_top;
  import rlim_pkg::*;
  logic clock, rst_n, clk_en, line_standard_select, single_rail_sel, rx_ready, hold_ready;
  logic line_receive_clock, positive_rail_in, negative_rail_in;
  logic loss_of_line_clock_flag, overrun_flag, rx_valid, rx_single_rail;
  rlim_std_type line_standard_mode;
  logic [BPV_W-1:0] bpv_count;
  logic [SAMPLES_PER_WORD-1:0] rx_pos_bits, rx_neg_bits;
  logic [16:0] lfsr_reg, rdy_lfsr;
  logic ep[$], en[$], rp[$], rn[$], rm[$];
  logic [1:0] em[$];
  int fail_count, n_compared, n_words, exp_bpv, cnt;

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  rlim_top rlim_top_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .line_receive_clock(line_receive_clock), .positive_rail_in(positive_rail_in),
    .negative_rail_in(negative_rail_in), .single_rail_sel(single_rail_sel),
    .line_standard_select(line_standard_select),
    .loss_of_line_clock_flag(loss_of_line_clock_flag),
    .line_standard_mode(line_standard_mode), .bpv_count(bpv_count),
    .overrun_flag(overrun_flag), .rx_valid(rx_valid), .rx_pos_bits(rx_pos_bits),
    .rx_neg_bits(rx_neg_bits), .rx_single_rail(rx_single_rail), .rx_ready(rx_ready));
  rlim_liu_model rlim_liu_model_i (.line_receive_clock(line_receive_clock),
    .positive_rail_in(positive_rail_in), .negative_rail_in(negative_rail_in));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  // Collect delivered words bit by bit, oldest first; random stalls
  always @(posedge clock) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      n_words++;
      for (int k = SAMPLES_PER_WORD - 1; k >= 0; k--) begin
        rp.push_back(rx_pos_bits[k]);
        rn.push_back(rx_neg_bits[k]);
        rm.push_back(rx_single_rail);
      end
    end
    rdy_lfsr <= lfsr_next(rdy_lfsr);
    rx_ready <= !hold_ready && (rdy_lfsr[2:0] != 3'h0);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic do_reset(input logic sel);
    @(posedge clock);
    rst_n <= 1'b0;
    line_standard_select <= sel;
    fork
      repeat (2) rlim_liu_model_i.send_bit(1'b0, 1'b0);
      repeat (2) @(posedge clock);
    join
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    `CHK(line_standard_mode, rlim_std_type'(sel), "mode after reset")
  endtask

  // Mode 0 dual rail, 1 single rail, 2 padding of zeros
  task automatic send_run(input int nbits, input logic [1:0] mode);
    logic p, n;
    for (int i = 0; i < nbits; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      p = (mode == 2'h2) ? 1'b0 : lfsr_reg[0];
      n = (mode == 2'h2) ? 1'b0 : lfsr_reg[5];
      rlim_liu_model_i.send_bit(p, n);
      ep.push_back(p);
      en.push_back(n);
      em.push_back(mode);
      if (mode == 2'h1) exp_bpv += n;
    end
  endtask

  // Padding on both sides keeps every data word inside one mode
  task automatic switch_mode(input logic m);
    send_run(8, 2'h2);
    @(posedge clock);
    single_rail_sel <= m;
    send_run(16, 2'h2);
  endtask

  task automatic drain();
    int quiet;
    quiet = 0;
    for (int i = 0; i < 2000 && quiet < 40; i++) begin
      @(posedge clock);
      quiet = (rx_valid === 1'b1) ? 0 : quiet + 1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    line_standard_select = 1'b0;
    single_rail_sel = 1'b0;
    rx_ready = 1'b0;
    hold_ready = 1'b0;
    lfsr_reg = 17'd79916;
    rdy_lfsr = 17'd79916;
    do_reset(1'b1);
    do_reset(1'b0);
    $display("test reset done");
    for (int i = 0; i < 24; i++) rlim_liu_model_i.send_bit(1'b0, 1'b0);
    // Marker bit: the first one on the positive rail aligns the streams
    ep.push_back(1'b1);
    en.push_back(1'b1);
    em.push_back(2'h0);
    rlim_liu_model_i.send_bit(1'b1, 1'b1);
    send_run(64, 2'h0);
    switch_mode(1'b1);
    send_run(64, 2'h1);
    switch_mode(1'b0);
    send_run(32, 2'h0);
    send_run(8, 2'h2);
    rlim_liu_model_i.stop();
    drain();
    while (rp.size() > 0 && rp[0] !== 1'b1) begin
      void'(rp.pop_front());
      void'(rn.pop_front());
      void'(rm.pop_front());
    end
    `CHK(rp.size() + 8 >= ep.size(), 1'b1, "word count")
    for (int i = 0; i < ep.size() && i < rp.size(); i++) begin
      `CHK(rp[i], ep[i], "positive rail bit")
      if (em[i] == 2'h0) `CHK(rn[i], en[i], "negative rail bit")
      if (em[i] != 2'h2) `CHK(rm[i], em[i][0], "rail mode of word")
    end
    `CHK(bpv_count, BPV_W'(exp_bpv), "violation count")
    `CHK(loss_of_line_clock_flag, 1'b0, "flag while clock runs")
    $display("test stream done");
    @(posedge clock);
    hold_ready <= 1'b1;
    for (int i = 0; i < 160; i++) rlim_liu_model_i.send_bit(lfsr_reg[i % 17], 1'b0);
    rlim_liu_model_i.stop();
    // Let words still crossing land before the framer starts taking again
    repeat (10) @(posedge clock);
    `CHK(overrun_flag, 1'b1, "overrun on full buffer")
    n_words = 0;
    hold_ready <= 1'b0;
    drain();
    `CHK(n_words, FIFO_DEPTH + 1, "words kept through stall")
    $display("test overrun done");
    repeat (2000) @(posedge clock);
    `CHK(loss_of_line_clock_flag, 1'b0, "flag before interval")
    rlim_liu_model_i.lone_edge();
    // Enable low for 100 cycles freezes the timer and stretches the interval
    repeat (1000) @(posedge clock);
    clk_en <= 1'b0;
    repeat (100) @(posedge clock);
    clk_en <= 1'b1;
    cnt = 1100;
    while (loss_of_line_clock_flag !== 1'b1 && cnt < 3000) begin
      @(posedge clock);
      cnt++;
    end
    `CHK(cnt >= 2595 && cnt <= 2606, 1'b1, "loss interval from edge")
    rlim_liu_model_i.lone_edge();
    repeat (6) @(posedge clock);
    `CHK(loss_of_line_clock_flag, 1'b0, "flag cleared by edge")
    $display("test clock loss done");
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
